// ---- src/mtsc_map.vh ----
`ifndef MTSC_MAP_VH
`define MTSC_MAP_VH
// Byte offsets of the counter bank
`define MTSC_TOR_LO_OFS      16'h40c0
`define MTSC_TOR_HI_OFS      16'h40c4
`define MTSC_TOT_LO_OFS      16'h40c8
`define MTSC_TOT_HI_OFS      16'h40cc
`define MTSC_TPR_OFS         16'h40d0
`define MTSC_TPT_OFS         16'h40d4
`define MTSC_BIN64_OFS       16'h40d8
`define MTSC_BIN127_OFS      16'h40dc
`define MTSC_BIN255_OFS      16'h40e0
`define MTSC_BIN511_OFS      16'h40e4
`define MTSC_BIN1023_OFS     16'h40e8
`define MTSC_M2H_OFS         16'h4158
`define MTSC_H2M_SENT_OFS    16'h415c
`define MTSC_H2M_DELIV_OFS   16'h8fe4
// Control register: bit 0 receive enable, bit 1 transmit enable
`define MTSC_CTRL_OFS        16'h4000
`define MTSC_CTRL_RXEN_BIT   0
`define MTSC_CTRL_TXEN_BIT   1
`define MTSC_CTRL_RESET      2'h0
`define MTSC_CNT_RESET       32'h00000000
// Size bin limits, destination address through CRC
`define MTSC_LEN_MIN         16'h0040
`define MTSC_LEN_127         16'h007f
`define MTSC_LEN_255         16'h00ff
`define MTSC_LEN_511         16'h01ff
`define MTSC_LEN_1023        16'h03ff
`define MTSC_RUNT_LEN        16'h0019
`endif

// ---- src/mtsc_stat_bank.v ----
`timescale 1ns/1ps
`include "mtsc_map.vh"

module mtsc_stat_bank (
   input  wire        mclk,
   input  wire        sys_rst,
   // Software reset and PCIe reset, one-cycle pulses
   input  wire        sw_reset,
   input  wire        pcie_reset,
   // Wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [15:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         wb_err_o,
   // Receive packet-done strobe
   input  wire        rx_done,
   input  wire [15:0] rx_len,
   input  wire        rx_pass_filter,
   input  wire        rx_bcast,
   // Transmit packet-done strobe
   input  wire        tx_done,
   input  wire [15:0] tx_len,
   input  wire        tx_partial,
   input  wire        tx_flow_ctrl,
   // Management traffic events
   input  wire        mgmt_to_host_pkt,
   input  wire        host_to_mgmt_deliv,
   input  wire        host_to_mgmt_sent,
   input  wire        host_to_mgmt_sec_drop,
   output reg  [1:0]  ctrl_out
);

   wire [63:0] tor_reg;
   wire [63:0] tot_reg;
   wire [31:0] tpr_reg;
   wire [31:0] tpt_reg;
   wire [31:0] bin_reg [0:4];
   wire [31:0] m2h_reg;
   wire [31:0] h2m_sent_reg;
   wire [31:0] h2m_deliv_reg;
   reg  [31:0] tor_hi_snap_reg;
   reg  [31:0] tot_hi_snap_reg;
   reg  [1:0]  ctrl_reg;
   reg  [31:0] rd_next;
   reg         hit_next;
   reg  [4:0]  bin_hit;
   reg  [13:0] rd_clr;
   wire        clr_all;
   wire        req;
   wire        rd;
   wire        rx_cnt;
   wire        tx_ok;

   // A request is served once; ack drops the cycle after it is given
   assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign rd      = req & ~wb_we_i;
   assign clr_all = sys_rst | sw_reset | pcie_reset;
   // Rx qualifier: enabled, passed filter or rejected broadcast, not a runt
   assign rx_cnt  = rx_done & ctrl_reg[`MTSC_CTRL_RXEN_BIT]
                    & (rx_pass_filter | rx_bcast)
                    & (rx_len >= `MTSC_RUNT_LEN);
   // Tx qualifier: enabled and completed
   assign tx_ok   = tx_done & ctrl_reg[`MTSC_CTRL_TXEN_BIT] & ~tx_partial;

   // Size bin decode
   always @* begin
      bin_hit[0] = (tx_len == `MTSC_LEN_MIN) & ~tx_flow_ctrl;
      bin_hit[1] = (tx_len > `MTSC_LEN_MIN) & (tx_len <= `MTSC_LEN_127);
      bin_hit[2] = (tx_len > `MTSC_LEN_127) & (tx_len <= `MTSC_LEN_255);
      bin_hit[3] = (tx_len > `MTSC_LEN_255) & (tx_len <= `MTSC_LEN_511);
      bin_hit[4] = (tx_len > `MTSC_LEN_511) & (tx_len <= `MTSC_LEN_1023);
   end

   // Read mux; high halves return the snapshot taken at the low read
   always @* begin
      rd_next  = 32'h00000000;
      hit_next = 1'b1;
      rd_clr   = 14'h0000;
      case (wb_adr_i)
         `MTSC_TOR_LO_OFS:    begin rd_next = tor_reg[31:0];   rd_clr[0]  = 1'b1; end
         `MTSC_TOR_HI_OFS:    begin rd_next = tor_hi_snap_reg; rd_clr[1]  = 1'b1; end
         `MTSC_TOT_LO_OFS:    begin rd_next = tot_reg[31:0];   rd_clr[2]  = 1'b1; end
         `MTSC_TOT_HI_OFS:    begin rd_next = tot_hi_snap_reg; rd_clr[3]  = 1'b1; end
         `MTSC_TPR_OFS:       begin rd_next = tpr_reg;         rd_clr[4]  = 1'b1; end
         `MTSC_TPT_OFS:       begin rd_next = tpt_reg;         rd_clr[5]  = 1'b1; end
         `MTSC_BIN64_OFS:     begin rd_next = bin_reg[0];      rd_clr[6]  = 1'b1; end
         `MTSC_BIN127_OFS:    begin rd_next = bin_reg[1];      rd_clr[7]  = 1'b1; end
         `MTSC_BIN255_OFS:    begin rd_next = bin_reg[2];      rd_clr[8]  = 1'b1; end
         `MTSC_BIN511_OFS:    begin rd_next = bin_reg[3];      rd_clr[9]  = 1'b1; end
         `MTSC_BIN1023_OFS:   begin rd_next = bin_reg[4];      rd_clr[10] = 1'b1; end
         `MTSC_M2H_OFS:       begin rd_next = m2h_reg;         rd_clr[11] = 1'b1; end
         `MTSC_H2M_SENT_OFS:  begin rd_next = h2m_sent_reg;    rd_clr[12] = 1'b1; end
         `MTSC_H2M_DELIV_OFS: begin rd_next = h2m_deliv_reg;   rd_clr[13] = 1'b1; end
         `MTSC_CTRL_OFS:      rd_next = {30'h00000000, ctrl_reg};
         default:             hit_next = 1'b0;
      endcase
      if (!rd) begin
         rd_clr = 14'h0000;
      end
   end

   // Bus answer: ack one cycle after the request, err on unmapped address
   always @(posedge mclk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_reg <= `MTSC_CTRL_RESET;
         ctrl_out <= `MTSC_CTRL_RESET;
      end else begin
         wb_ack_o <= req & hit_next;
         wb_err_o <= req & ~hit_next;
         wb_dat_o <= rd ? rd_next : 32'h00000000;
         if (req & wb_we_i & (wb_adr_i == `MTSC_CTRL_OFS) & wb_sel_i[0]) begin
            ctrl_reg <= wb_dat_i[1:0];
         end
         ctrl_out <= ctrl_reg;
      end
   end

   // High-half snapshots; a low read freezes the upper word so the pair stays coherent
   // Limitation: a high read with no low read before it returns a zero word
   always @(posedge mclk) begin
      if (clr_all) begin
         tor_hi_snap_reg <= `MTSC_CNT_RESET;
         tot_hi_snap_reg <= `MTSC_CNT_RESET;
      end else begin
         if (rd_clr[0]) begin
            tor_hi_snap_reg <= tor_reg[63:32];
         end else if (rd_clr[1]) begin
            tor_hi_snap_reg <= `MTSC_CNT_RESET;
         end
         if (rd_clr[2]) begin
            tot_hi_snap_reg <= tot_reg[63:32];
         end else if (rd_clr[3]) begin
            tot_hi_snap_reg <= `MTSC_CNT_RESET;
         end
      end
   end

   // Received octets; the low read clears the whole 64-bit value
   // Snapshot above keeps the high word, so clearing here loses nothing
   mtsc_sat_acc #(
      .WIDTH   (64),
      .STEPW   (16)
   ) u_tor_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[0]),
      .inc     (rx_cnt),
      .step    (rx_len),
      .cnt_reg (tor_reg)
   );

   // Transmitted octets, flow control included, partial sends left out
   // Same read pairing as the receive side
   mtsc_sat_acc #(
      .WIDTH   (64),
      .STEPW   (16)
   ) u_tot_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[2]),
      .inc     (tx_ok),
      .step    (tx_len),
      .cnt_reg (tot_reg)
   );

   // Received packets, same qualifier as the received octets
   // Runts fall out through the qualifier, truncated packets stay in
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_tpr_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[4]),
      .inc     (rx_cnt),
      .step    (1'b1),
      .cnt_reg (tpr_reg)
   );

   // Transmitted packets from every source
   // Collision aborts never reach tx_ok
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_tpt_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[5]),
      .inc     (tx_ok),
      .step    (1'b1),
      .cnt_reg (tpt_reg)
   );

   // Size bin, exactly minimum length, flow control excluded by the decode
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_bin_min_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[6]),
      .inc     (tx_ok & bin_hit[0]),
      .step    (1'b1),
      .cnt_reg (bin_reg[0])
   );

   // Size bin up to 127 bytes
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_bin_127_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[7]),
      .inc     (tx_ok & bin_hit[1]),
      .step    (1'b1),
      .cnt_reg (bin_reg[1])
   );

   // Size bin up to 255 bytes
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_bin_255_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[8]),
      .inc     (tx_ok & bin_hit[2]),
      .step    (1'b1),
      .cnt_reg (bin_reg[2])
   );

   // Size bin up to 511 bytes
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_bin_511_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[9]),
      .inc     (tx_ok & bin_hit[3]),
      .step    (1'b1),
      .cnt_reg (bin_reg[3])
   );

   // Size bin up to 1023 bytes; longer packets land in no bin here
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_bin_1023_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[10]),
      .inc     (tx_ok & bin_hit[4]),
      .step    (1'b1),
      .cnt_reg (bin_reg[4])
   );

   // Management-to-host packets, one strobe per replication
   // No enable gating: these run whatever the MAC enables say
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_m2h_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[11]),
      .inc     (mgmt_to_host_pkt),
      .step    (1'b1),
      .cnt_reg (m2h_reg)
   );

   // Host-to-management sends; congestion drops count, security drops do not
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_h2m_sent_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[12]),
      .inc     (host_to_mgmt_sent & ~host_to_mgmt_sec_drop),
      .step    (1'b1),
      .cnt_reg (h2m_sent_reg)
   );

   // Host packets that reached the sideband interface
   mtsc_sat_acc #(
      .WIDTH   (32),
      .STEPW   (1)
   ) u_h2m_deliv_cnt (
      .mclk    (mclk),
      .clr     (clr_all),
      .rd_clr  (rd_clr[13]),
      .inc     (host_to_mgmt_deliv),
      .step    (1'b1),
      .cnt_reg (h2m_deliv_reg)
   );

endmodule // mtsc_stat_bank

// Saturating accumulator with clear-on-read
// One module for every counter keeps the set-wins and stop-at-max behaviour identical
module mtsc_sat_acc #(
   parameter WIDTH = 32,
   parameter STEPW = 1
) (
   input  wire             mclk,
   input  wire             clr,
   input  wire             rd_clr,
   input  wire             inc,
   input  wire [STEPW-1:0] step,
   output reg  [WIDTH-1:0] cnt_reg
);

   wire [WIDTH-1:0] step_ext;
   wire [WIDTH:0]   sum;

   // Step widened on purpose; the extra top bit of the sum flags overflow
   assign step_ext = {{(WIDTH - STEPW){1'b0}}, step};
   assign sum      = {1'b0, cnt_reg} + {1'b0, step_ext};

   // Resets win over all; a read clear with an event in the same cycle keeps that event
   // Trade-off: the event is never lost, at the cost of a non-zero value right after a read
   always @(posedge mclk) begin
      if (clr) begin
         cnt_reg <= {WIDTH{1'b0}};
      end else if (rd_clr) begin
         cnt_reg <= inc ? step_ext : {WIDTH{1'b0}};
      end else if (inc) begin
         // Stick at all ones rather than wrap back to zero
         cnt_reg <= sum[WIDTH] ? {WIDTH{1'b1}} : sum[WIDTH-1:0];
      end
   end

endmodule // mtsc_sat_acc

// ---- testbench/mtsc_stat_bank_properties.sv ----
`timescale 1ns/1ps
module mtsc_stat_bank_props (
   input wire        mclk,
   input wire        sys_rst,
   input wire        sw_reset,
   input wire        pcie_reset,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [15:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        wb_err_o,
   input wire        rx_done,
   input wire        tx_done,
   input wire        mgmt_to_host_pkt,
   input wire        host_to_mgmt_deliv,
   input wire        host_to_mgmt_sent
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // New request and decode of the mapped offsets
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire hit = (wb_adr_i >= 16'h40c0 && wb_adr_i <= 16'h40e8 && wb_adr_i[1:0] == 2'h0) || wb_adr_i == 16'h4000 ||
              wb_adr_i == 16'h4158 || wb_adr_i == 16'h415c || wb_adr_i == 16'h8fe4;
   wire ev = rx_done || tx_done || mgmt_to_host_pkt || host_to_mgmt_deliv || host_to_mgmt_sent;
   // No event since a clear; high halves skipped, they hold a snapshot
   reg quiet_reg;
   always @(posedge mclk) quiet_reg <= sys_rst || sw_reset || pcie_reset || (quiet_reg && !ev);
   chk_take_answer: assert property (req |=> wb_ack_o || wb_err_o) else $error("request not answered");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_ack_err_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
   chk_err_unmapped: assert property (req && !hit |=> wb_err_o) else $error("unmapped without err");
   chk_ack_mapped: assert property (req && hit |=> wb_ack_o) else $error("mapped without ack");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
   chk_reset_quiet: assert property ($fell(sys_rst) |-> !wb_ack_o && !wb_err_o) else $error("answer in reset");
   chk_clear_reads: assert property (wb_ack_o && quiet_reg && $past(quiet_reg) && !wb_we_i &&
      wb_adr_i != 16'h4000 && wb_adr_i != 16'h40c4 && wb_adr_i != 16'h40cc |-> wb_dat_o == 32'h0)
      else $error("counter not cleared");
endmodule // mtsc_stat_bank_props
bind mtsc_stat_bank mtsc_stat_bank_props u_props (.mclk, .sys_rst, .sw_reset, .pcie_reset, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .rx_done, .tx_done, .mgmt_to_host_pkt,
   .host_to_mgmt_deliv, .host_to_mgmt_sent);

// ---- testbench/mac_traffic_statistics_counters_tb.sv ----
`timescale 1ns/1ps
`define MTSC_CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module mac_traffic_statistics_counters_tb;
   logic        mclk = 0, sys_rst = 1, sw_reset = 0, pcie_reset = 0, cyc = 0, we = 0;
   logic        rx_done = 0, tx_done = 0, f1 = 0, f2 = 0, got_err, ack, err;
   logic [3:0]  mg = 0;
   logic [15:0] adr = 0, len = 0;
   logic [31:0] wdat = 0, rdat, got;
   logic [1:0]  ctrl;
   int          errors = 0, n_tests = 0, i;
   logic [15:0] tl [0:11] = '{64, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 100};
   mtsc_stat_bank u_dut (.mclk, .sys_rst, .sw_reset, .pcie_reset, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
      .rx_done, .rx_len(len), .rx_pass_filter(f1), .rx_bcast(f2), .tx_done, .tx_len(len), .tx_partial(f2),
      .tx_flow_ctrl(f1), .mgmt_to_host_pkt(mg[0]), .host_to_mgmt_deliv(mg[1]), .host_to_mgmt_sent(mg[2]),
      .host_to_mgmt_sec_drop(mg[3]), .ctrl_out(ctrl));
   // Free-running 100 MHz clock
   always #5 mclk = ~mclk;
   // One classic cycle; request held until ack or err is sampled
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1 && err !== 1'b1);
      got_err = err;
      got = rdat;
      cyc <= 0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      bus(0, a, 32'h0);
      `MTSC_CHK($sformatf("reg %h", a), e, got)
   endtask
   // One-cycle event: k 1 receive, 2 transmit; f1/f2 are pass/bcast or flow/partial
   task automatic ev(input logic [1:0] k, input logic [15:0] l, input logic a, input logic b, input logic [3:0] m);
      @(posedge mclk);
      rx_done <= k[0];
      tx_done <= k[1];
      len <= l;
      f1 <= a;
      f2 <= b;
      mg <= m;
      @(posedge mclk);
      {rx_done, tx_done, mg} <= 6'h0;
   endtask
   function automatic logic [15:0] ra(input int j);
      return j < 11 ? 16'h40c0 + 16'(4 * j) : j == 11 ? 16'h4158 : j == 12 ? 16'h415c : j == 13 ? 16'h8fe4 : 16'h4000;
   endfunction
   task automatic tally_and_finish;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog far beyond the few hundred cycles of the sequence
   initial begin
      #100000;
      errors++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge mclk);
      sys_rst <= 0;
      for (i = 0; i < 15; i++) rd(ra(i), 32'h0);
      // Enables still clear: nothing may count
      ev(1, 16'h64, 1, 0, 4'h0);
      ev(2, 16'h64, 0, 0, 4'h0);
      rd(16'h40d0, 32'h0);
      rd(16'h40c8, 32'h0);
      bus(0, 16'h4004, 32'h0);
      `MTSC_CHK("err", 1'b1, got_err)
      bus(1, 16'h4000, 32'h3);
      rd(16'h4000, 32'h3);
      `MTSC_CHK("ctrl", 2'h3, ctrl)
      // Pass, rejected bcast, rejected, runt, shortest counted
      ev(1, 16'h64, 1, 0, 4'h0);
      ev(1, 16'h50, 0, 1, 4'h0);
      ev(1, 16'h5a, 0, 0, 4'h0);
      ev(1, 16'h18, 1, 0, 4'h0);
      ev(1, 16'h19, 1, 0, 4'h0);
      rd(16'h40d0, 32'h3);
      rd(16'h40c0, 32'hcd);
      rd(16'h40c4, 32'h0);
      rd(16'h40c0, 32'h0);
      // Bin edges; index 1 flow control, index 11 collision abort
      for (i = 0; i < 12; i++) ev(2, tl[i], i == 1, i == 11, 4'h0);
      rd(16'h40d4, 32'hb);
      rd(16'h40c8, 32'hfbd);
      rd(16'h40cc, 32'h0);
      for (i = 0; i < 5; i++) rd(ra(6 + i), i == 0 ? 32'h1 : 32'h2);
      for (i = 0; i < 8; i++) ev(0, 16'h0, 0, 0, i < 3 ? 4'h1 : i < 5 ? 4'h2 : i < 7 ? 4'h4 : 4'hc);
      rd(16'h4158, 32'h3);
      rd(16'h8fe4, 32'h2);
      rd(16'h415c, 32'h2);
      rd(16'h4158, 32'h0);
      // Software reset, then PCIe reset, each wiping fresh counts
      for (i = 0; i < 2; i++) begin
         ev(1, 16'h64, 1, 0, 4'h7);
         @(posedge mclk);
         sw_reset <= i == 0;
         pcie_reset <= i == 1;
         @(posedge mclk);
         {sw_reset, pcie_reset} <= 2'h0;
         rd(16'h40d0, 32'h0);
         rd(16'h415c, 32'h0);
      end
      tally_and_finish;
   end
endmodule // mac_traffic_statistics_counters_tb
